// *** hw/pfm_pkg.sv ***
// shared constants for the pad-function multiplexer
package pfm_pkg;
  // register byte offsets
  localparam logic [7:0]  PAD_MODE_OFFSET  = 8'h00;
  localparam logic [7:0]  CLK_MODE_OFFSET  = 8'h04;
  localparam logic [31:0] PAD_MODE_RESET   = 32'h00000000;
  // field positions in pad_mode_control_two
  localparam int CAN_SEL_LSB    = 0;
  localparam int CAN_SEL_W      = 2;
  localparam int LINK_SEL_LSB   = 2;
  localparam int LINK_SEL_W     = 3;
  localparam int POLARITY_BIT   = 8;
  localparam int CS_SEL_LSB     = 26;
  localparam int CS_SEL_W       = 4;
  localparam int PAD_MODE_W     = 30;
  // can selector encoding
  localparam logic [1:0] CAN_ON_SERIAL = 2'h2;
  // widths
  localparam int CODE_W    = 4;
  localparam int DECODE_W  = 8;
  localparam int CS_PAD_LO = 4;
  localparam int MODE_W    = 3;
endpackage

// *** hw/pfm_pad_function_multiplexer.sv ***
// pad-function multiplexer with apb registers and chip-select decoder
// What this block does
// [RULE1] bit 26: timer clock b or cs4
// [RULE2] bit 27: timer clock a or cs5
// [RULE3] bit 28: trigger one or cs6
// [RULE4] bit 29: trigger two or cs7
// [RULE5] can selector 00 keeps serial, gpio
// [RULE6] can selector x1 puts can on multipurpose
// [RULE7] can selector 10 puts can on serial
// [RULE8] link selector x00 routes nothing
// [RULE9] 001 routes tx0, sync, clock
// [RULE10] 010 routes rx0, sync, clock
// [RULE11] 011 routes rx0, tx0, sync, clock
// [RULE12] 101 routes tx0, tx1, sync, clock
// [RULE13] 110 routes rx0, rx1, sync, clock
// [RULE14] 111 routes every link signal
// [RULE15] code decodes one-hot, polarity inverts
// [RULE16] irq pins configure clock during reset
// [RULE17] clock mode latched at reset release
// [RULE18] bits 30, 31 read zero
`timescale 1ns/1ps
module pfm_pad_function_multiplexer
  import pfm_pkg::*;
(
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // chip-select shared pads, index 0..3 for cs4..cs7
  input  wire logic [3:0]          csPadIn,
  output logic [3:0]               csPadOut,
  output logic [3:0]               csPadOe,
  // timer and trigger inputs fed from those pads
  output logic                     timerTwoClockB,
  output logic                     timerTwoClockA,
  output logic                     externalTriggerOne,
  output logic                     externalTriggerTwo,
  // chip-select decoder
  input  wire logic [CODE_W-1:0]   chipSelectCodeIn,
  output logic [DECODE_W-1:0]      decodedChipSelects,
  // serial and can pads
  output logic                     serialTxPadOut,
  input  wire logic                serialRxPadIn,
  input  wire logic                serialTwoTransmit,
  output logic                     serialTwoReceive,
  input  wire logic                canCTransmit,
  output logic                     canCReceive,
  // multipurpose pads 10..15, index 0..5
  input  wire logic [5:0]          mpioPadIn,
  output logic [5:0]               mpioPadOut,
  output logic [5:0]               mpioPadOe,
  input  wire logic [5:0]          mpioOut,
  input  wire logic [5:0]          mpioOe,
  output logic [5:0]               mpioIn,
  // pwm pads, index 0 is channel two, 1 is channel three
  input  wire logic [1:0]          pwmPadIn,
  output logic [1:0]               pwmPadOut,
  output logic [1:0]               pwmPadOe,
  input  wire logic [1:0]          pwmOut,
  // link peripheral side
  output logic                     linkReceiveZero,
  output logic                     linkReceiveOne,
  input  wire logic                linkTransmitZero,
  input  wire logic                linkTransmitOne,
  input  wire logic                linkSync,
  input  wire logic                linkClock,
  // interrupt and clock-mode pins
  input  wire logic [MODE_W-1:0]   irqPadIn,
  output logic [MODE_W-1:0]        irqRequest,
  output logic [MODE_W-1:0]        clockModeConfigPins
);

  // stored control bits, reserved top bits not kept
  logic [PAD_MODE_W-1:0] padMode;
  logic [CAN_SEL_W-1:0]  canSel;
  logic [LINK_SEL_W-1:0] linkSel;
  logic                  polarity;
  logic                  setupRd;
  logic                  hit;
  logic                  next_serialTx;
  logic                  next_serialRx;
  logic                  next_canRx;
  logic [5:0]            next_mpioOut;
  logic [5:0]            next_mpioOe;
  logic [1:0]            next_pwmOut;
  logic [1:0]            next_pwmOe;
  logic                  next_link0;
  logic                  next_link1;
  logic [DECODE_W-1:0]   next_decoded;

  assign canSel   = padMode[CAN_SEL_LSB +: CAN_SEL_W];
  assign linkSel  = padMode[LINK_SEL_LSB +: LINK_SEL_W];
  assign polarity = padMode[POLARITY_BIT];
  assign setupRd  = psel && !penable;
  assign hit      = (paddr == PAD_MODE_OFFSET) || (paddr == CLK_MODE_OFFSET);

  // zero-wait answer in the access phase
  assign pready  = psel && penable;
  assign pslverr = psel && penable && !hit;

  // register write, only the control word is writable
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      padMode <= PAD_MODE_RESET[PAD_MODE_W-1:0];
    end
    else if (psel && penable && pwrite && paddr == PAD_MODE_OFFSET)
    begin
      // bits 30 and 31 are dropped here
      // [RULE18] reserved ignored
      padMode <= pwdata[PAD_MODE_W-1:0];
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      prdata <= '0;
    end
    else if (setupRd && !pwrite)
    begin
      // [RULE18] reserved read zero
      if (paddr == PAD_MODE_OFFSET)
      begin
        prdata <= {2'h0, padMode};
      end
      else if (paddr == CLK_MODE_OFFSET)
      begin
        prdata <= {29'h0, clockModeConfigPins};
      end
      else
      begin
        prdata <= '0;
      end
    end
  end

  // chip-select pads, one per select bit
  genvar g;
  generate
    for (g = 0; g < CS_SEL_W; g++)
    begin : gCsPad
      always_ff @(posedge sys_clk)
      begin
        if (sys_rst)
        begin
          csPadOut[g] <= 1'b0;
          csPadOe[g]  <= 1'b0;
        end
        else
        begin
          // [RULE1] pad select drive
          csPadOe[g]  <= padMode[CS_SEL_LSB + g];
          csPadOut[g] <= next_decoded[CS_PAD_LO + g];
        end
      end
    end
  endgenerate

  // timer and trigger inputs only see the pad when selected as input
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      timerTwoClockB     <= 1'b0;
      timerTwoClockA     <= 1'b0;
      externalTriggerOne <= 1'b0;
      externalTriggerTwo <= 1'b0;
    end
    else
    begin
      // [RULE1] timer clock b
      timerTwoClockB     <= csPadIn[0] && !padMode[CS_SEL_LSB];
      // [RULE2] timer clock a
      timerTwoClockA     <= csPadIn[1] && !padMode[CS_SEL_LSB + 1];
      // [RULE3] trigger one
      externalTriggerOne <= csPadIn[2] && !padMode[CS_SEL_LSB + 2];
      // [RULE4] trigger two
      externalTriggerTwo <= csPadIn[3] && !padMode[CS_SEL_LSB + 3];
    end
  end

  // one-hot decode with optional inversion
  always_comb
  begin
    // [RULE15] decode and invert
    next_decoded = '0;
    next_decoded[chipSelectCodeIn[2:0]] = !chipSelectCodeIn[3];
    if (polarity)
    begin
      next_decoded = ~next_decoded;
    end
  end

  // registered decoder output
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      decodedChipSelects <= '0;
    end
    else
    begin
      decodedChipSelects <= next_decoded;
    end
  end

  // routing for can, link and default functions
  always_comb
  begin
    next_mpioOut  = mpioOut;
    next_mpioOe   = mpioOe;
    next_pwmOut   = pwmOut;
    next_pwmOe    = 2'h3;
    next_serialTx = serialTwoTransmit;
    next_serialRx = serialRxPadIn;
    next_canRx    = 1'b0;
    next_link0    = 1'b0;
    next_link1    = 1'b0;
    // [RULE5] default serial and gpio
    if (canSel[0])
    begin
      // [RULE6] can on multipurpose
      next_canRx      = mpioPadIn[1];
      next_mpioOe[1]  = 1'b0;
      next_mpioOut[2] = canCTransmit;
      next_mpioOe[2]  = 1'b1;
    end
    else if (canSel == CAN_ON_SERIAL)
    begin
      // [RULE7] can on serial
      next_canRx    = serialRxPadIn;
      next_serialRx = 1'b0;
      next_serialTx = canCTransmit;
    end
    // [RULE8] x00 routes none
    // [RULE9] sync and clock
    if (linkSel[1:0] != 2'h0)
    begin
      next_mpioOut[0] = linkSync;
      next_mpioOe[0]  = 1'b1;
      next_mpioOut[3] = linkClock;
      next_mpioOe[3]  = 1'b1;
    end
    // [RULE10] receive zero
    if (linkSel[1])
    begin
      next_link0     = mpioPadIn[4];
      next_mpioOe[4] = 1'b0;
    end
    // [RULE11] transmit zero
    if (linkSel[0])
    begin
      next_mpioOut[5] = linkTransmitZero;
      next_mpioOe[5]  = 1'b1;
    end
    // [RULE12] transmit one
    if (linkSel[2] && linkSel[0])
    begin
      next_pwmOut[0] = linkTransmitOne;
    end
    // [RULE13] receive one
    if (linkSel[2] && linkSel[1])
    begin
      // [RULE14] all six routed
      next_link1     = pwmPadIn[1];
      next_pwmOe[1]  = 1'b0;
    end
  end

  // registered pad and peripheral sides
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      serialTxPadOut   <= 1'b0;
      serialTwoReceive <= 1'b0;
      canCReceive      <= 1'b0;
      mpioPadOut       <= '0;
      mpioPadOe        <= '0;
      mpioIn           <= '0;
      pwmPadOut        <= '0;
      pwmPadOe         <= '0;
      linkReceiveZero  <= 1'b0;
      linkReceiveOne   <= 1'b0;
    end
    else
    begin
      serialTxPadOut   <= next_serialTx;
      serialTwoReceive <= next_serialRx;
      canCReceive      <= next_canRx;
      mpioPadOut       <= next_mpioOut;
      mpioPadOe        <= next_mpioOe;
      mpioIn           <= mpioPadIn;
      pwmPadOut        <= next_pwmOut;
      pwmPadOe         <= next_pwmOe;
      linkReceiveZero  <= next_link0;
      linkReceiveOne   <= next_link1;
    end
  end

  // clock mode follows pins during reset, frozen at release
  always_ff @(posedge sys_clk)
  begin
    // [RULE17] latch at release
    if (sys_rst)
    begin
      clockModeConfigPins <= irqPadIn;
    end
  end

  // interrupt requests only once reset is gone
  always_ff @(posedge sys_clk)
  begin
    // [RULE16] irq after reset
    if (sys_rst)
    begin
      irqRequest <= '0;
    end
    else
    begin
      irqRequest <= irqPadIn;
    end
  end

endmodule

// *** verif/pfm_asserts.sv ***
// port checker for the pad-function multiplexer
`timescale 1ns/1ps
module pfm_asserts
  import pfm_pkg::*;
(
  // clock, reset and apb
  input wire logic                sys_clk,
  input wire logic                sys_rst,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         prdata,
  input wire logic                pslverr,
  // chip-select pads and decoder
  input wire logic [3:0]          csPadIn,
  input wire logic [3:0]          csPadOut,
  input wire logic [3:0]          csPadOe,
  input wire logic                timerTwoClockB,
  input wire logic                timerTwoClockA,
  input wire logic                externalTriggerOne,
  input wire logic                externalTriggerTwo,
  input wire logic [CODE_W-1:0]   chipSelectCodeIn,
  input wire logic [DECODE_W-1:0] decodedChipSelects,
  // interrupt and clock-mode pins
  input wire logic [MODE_W-1:0]   irqPadIn,
  input wire logic [MODE_W-1:0]   irqRequest,
  input wire logic [MODE_W-1:0]   clockModeConfigPins
);
  logic [7:0] dx;  // one-hot pattern of the last code
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // expected pattern, one cycle behind the code
  always_ff @(posedge sys_clk)
  begin
    dx <= chipSelectCodeIn[3] ? 8'h00 : 8'h01 << chipSelectCodeIn[2:0];
  end
  a_pad_input_gate: assert property (
    !$past(sys_rst) |-> {externalTriggerTwo, externalTriggerOne, timerTwoClockA,
    timerTwoClockB} == ($past(csPadIn) & ~csPadOe)) else $error("pad input gating wrong");
  a_oe_write_cause: assert property (
    !$stable(csPadOe) |-> $past(psel, 2) && $past(penable, 2) && $past(pwrite, 2))
    else $error("pad enable moved without a write");
  a_decode_pattern: assert property (
    !$past(sys_rst) |-> decodedChipSelects == dx || decodedChipSelects == ~dx)
    else $error("decoder pattern wrong");
  a_cs_pad_out: assert property (
    csPadOut == decodedChipSelects[7:4]) else $error("chip-select pads differ");
  a_reserved_zero: assert property (
    psel && !penable && !pwrite && paddr == PAD_MODE_OFFSET |=> prdata[31:30] == 2'h0)
    else $error("reserved bits read nonzero");
  a_irq_track: assert property (
    irqRequest == ($past(sys_rst) ? 3'h0 : $past(irqPadIn))) else $error("irq wrong");
  a_mode_latch: assert property (
    $past(sys_rst) |-> clockModeConfigPins == $past(irqPadIn)) else $error("mode not latched");
  a_mode_frozen: assert property (
    !$past(sys_rst) |-> $stable(clockModeConfigPins)) else $error("mode moved");
  c_unmapped: cover property (pslverr);
  c_all_pads: cover property (csPadOe == 4'hf);
  c_inverted: cover property (decodedChipSelects == 8'hfe);
endmodule

// *** verif/test_pfm_pad_function_multiplexer.sv ***
// self-checking bench for the pad-function multiplexer
`timescale 1ns/1ps
module test_pfm_pad_function_multiplexer;
  import pfm_pkg::*;
  logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, serr;
  logic [7:0]  paddr, decodedChipSelects;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  csPadIn, chipSelectCodeIn, csPadOut, csPadOe;
  logic        timerTwoClockB, timerTwoClockA, externalTriggerOne, externalTriggerTwo;
  logic        serialTxPadOut, serialRxPadIn, serialTwoTransmit, serialTwoReceive;
  logic        canCTransmit, canCReceive, linkSync, linkClock;
  logic [5:0]  mpioPadIn, mpioPadOut, mpioPadOe, mpioOut, mpioOe, mpioIn;
  logic [1:0]  pwmPadIn, pwmPadOut, pwmPadOe, pwmOut;
  logic        linkReceiveZero, linkReceiveOne, linkTransmitZero, linkTransmitOne;
  logic [2:0]  irqPadIn, irqRequest, clockModeConfigPins;
  int          errCount, checkCount;
  // routing per link selector: rx0 tx0 rx1 tx1 sync-clock
  logic [4:0]  linkMap [8] = '{5'h00, 5'h09, 5'h11, 5'h19, 5'h00, 5'h0b, 5'h15, 5'h1f};
  pfm_pad_function_multiplexer i_pfm_pad_function_multiplexer (.*);
  // free-running system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checkCount++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      errCount++;
    end
  endtask
  task conclude;
    if (errCount == 0 && checkCount > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one apb transfer, bounded wait for pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      // a slave that never answers ends the run as a mismatch
      chk(pready, 1'b1, "pready");
      conclude;
    end
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // let registered pad outputs land
  task settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task do_reset(input logic [2:0] m);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    irqPadIn <= m;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
  endtask
  task t_regs;
    apb(1'b0, PAD_MODE_OFFSET, 32'h0);
    chk(rdat, PAD_MODE_RESET, "reset value");
    apb(1'b1, PAD_MODE_OFFSET, 32'hffffffff);
    apb(1'b0, PAD_MODE_OFFSET, 32'h0);
    chk(rdat[31:30], 2'h0, "reserved");
    apb(1'b0, 8'h08, 32'h0);
    chk(serr, 1'b1, "unmapped");
    apb(1'b1, PAD_MODE_OFFSET, 32'h0);
  endtask
  task t_cs;
    @(posedge sys_clk);
    csPadIn <= 4'ha;
    chipSelectCodeIn <= 4'h5;
    apb(1'b1, PAD_MODE_OFFSET, 32'h0c000000);
    settle;
    chk(csPadOe, 4'h3, "oe low");
    chk({externalTriggerTwo, externalTriggerOne, timerTwoClockA, timerTwoClockB}, 4'h8,
      "in low");
    chk(csPadOut, 4'h2, "cs out");
    apb(1'b1, PAD_MODE_OFFSET, 32'h30000000);
    settle;
    chk(csPadOe, 4'hc, "oe high");
    chk({externalTriggerTwo, externalTriggerOne, timerTwoClockA, timerTwoClockB}, 4'h2,
      "in high");
  endtask
  task t_decode;
    for (int p = 0; p < 2; p++)
    begin
      apb(1'b1, PAD_MODE_OFFSET, 32'(p) << POLARITY_BIT);
      for (int c = 0; c < 16; c++)
      begin
        @(posedge sys_clk);
        chipSelectCodeIn <= c[3:0];
        settle;
        chk(decodedChipSelects, (c < 8 ? 8'h01 << c : 8'h00) ^ {8{p[0]}}, "decode");
      end
    end
  endtask
  task t_can;
    logic [15:0] canMap;
    canMap = 16'he3ed;
    @(posedge sys_clk);
    {serialTwoTransmit, canCTransmit, serialRxPadIn} <= 3'h5;
    // gpio enable of io12 low, so a routed can transmit shows on its enable
    {mpioPadIn, mpioOut, mpioOe} <= {6'h02, 6'h3f, 6'h3b};
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, PAD_MODE_OFFSET, 32'(s));
      settle;
      chk({serialTxPadOut, serialTwoReceive, canCReceive, mpioPadOut[2]},
        canMap[s*4 +: 4], "can pads");
      chk(mpioPadOe, s[0] ? 6'h3d : 6'h3b, "can oe");
      chk(mpioIn, 6'h02, "gpio in");
    end
  endtask
  task t_link;
    @(posedge sys_clk);
    {linkTransmitZero, linkTransmitOne, linkSync, linkClock} <= 4'hf;
    // gpio enable only on io14, so link routing shows on the io10, io13, io14 and io15 enables and the pwm channel three enable
    {mpioPadIn, mpioOut, mpioOe, pwmPadIn, pwmOut} <= {6'h3f, 6'h00, 6'h10, 2'h3, 2'h0};
    for (int s = 0; s < 8; s++)
    begin
      apb(1'b1, PAD_MODE_OFFSET, 32'(s) << LINK_SEL_LSB);
      settle;
      chk({linkReceiveZero, mpioPadOut[5], linkReceiveOne, pwmPadOut[0],
        mpioPadOut[0] & mpioPadOut[3]}, linkMap[s], "link");
      chk({mpioPadOe, pwmPadOe}, {linkMap[s][3], ~linkMap[s][4], linkMap[s][0], 2'h0,
        linkMap[s][0], ~linkMap[s][2], 1'b1}, "link oe");
    end
  endtask
  task t_mode;
    do_reset(3'h5);
    @(posedge sys_clk);
    irqPadIn <= 3'h2;
    settle;
    chk(clockModeConfigPins, 3'h5, "mode pins");
    chk(irqRequest, 3'h2, "irq");
    apb(1'b0, CLK_MODE_OFFSET, 32'h0);
    chk(rdat[2:0], 3'h5, "mode reg");
  endtask
  // main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, csPadIn, chipSelectCodeIn} = '0;
    {serialRxPadIn, serialTwoTransmit, canCTransmit, mpioPadIn, mpioOut, mpioOe} = '0;
    {pwmPadIn, pwmOut, linkTransmitZero, linkTransmitOne, linkSync, linkClock} = '0;
    sys_rst = 1'b1;
    irqPadIn = 3'h3;
    errCount = 0;
    checkCount = 0;
    do_reset(3'h3);
    t_regs;
    t_cs;
    t_decode;
    t_can;
    t_link;
    t_mode;
    conclude;
  end
endmodule
bind pfm_pad_function_multiplexer pfm_asserts i_pfm_asserts (.*);
